// >>> src/bcs_pkg.sv
package bcs_pkg;

  // timing base
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_PERIOD_PS  = 1000000000;
  localparam int unsigned CYC_PER_MS    = MS_PERIOD_PS / CLK_PERIOD_PS;

  // timing limits in ms
  localparam logic [15:0] LONG_MIN_MS   = 16'd200;
  localparam logic [15:0] LONG_DEF_MS   = 16'd500;
  localparam logic [15:0] DELAY_MAX_MS  = 16'd20000;
  localparam logic [15:0] DELAY_DEF_MS  = 16'd0;

  // debounce choices in ms, selected by a 3-bit code
  localparam logic [7:0] DEB_MS_0 = 8'd10;
  localparam logic [7:0] DEB_MS_1 = 8'd20;
  localparam logic [7:0] DEB_MS_2 = 8'd30;
  localparam logic [7:0] DEB_MS_3 = 8'd40;
  localparam logic [7:0] DEB_MS_4 = 8'd50;
  localparam logic [7:0] DEB_MS_5 = 8'd70;
  localparam logic [7:0] DEB_MS_6 = 8'd100;
  localparam logic [7:0] DEB_MS_7 = 8'd150;
  localparam logic [2:0] DEB_SEL_DEF = 3'd4;

  localparam int unsigned NUM_SLOTS = 4;
  localparam logic [2:0] COUNT_MIN = 3'd2;
  localparam logic [2:0] COUNT_MAX = 3'd4;
  localparam logic [2:0] COUNT_DEF = 3'd3;

  localparam logic [7:0] PCT_FULL  = 8'd100;
  localparam logic [7:0] BYTE_FULL = 8'hff;
  localparam logic [7:0] HVAC_MAX  = 8'd4;

  typedef enum logic [1:0] {
    BCS_TYPE_BIT,
    BCS_TYPE_U8,
    BCS_TYPE_PCT,
    BCS_TYPE_HVAC
  } bcs_type_t;

  typedef struct packed {
    logic                  enable;
    logic                  contact_nc;
    logic                  long_en;
    logic                  single_obj;
    logic [2:0]            value_count;
    bcs_type_t             shared_type;
    logic [2:0]            debounce_sel;
    logic [15:0]           long_ms;
    logic [15:0]           delay_ms;
    logic [3:0]            slot_en;
    bcs_type_t [3:0]       slot_type;
    logic [3:0][7:0]       value_short;
    logic [3:0][7:0]       value_long;
  } bcs_cfg_t;

  typedef struct packed {
    logic [1:0] slot;
    bcs_type_t  dtype;
    logic       is_long;
    logic [7:0] data;
  } bcs_cmd_t;

endpackage

// >>> src/bcs_sequencer.sv
// Overview of operation
// - up to four command slots, each a bit, unsigned byte, percentage or HVAC mode.
// - each qualified press advances to next enabled slot, first to fourth, emitting it.
// - a config bit marks contact normally closed or open; polarity inverted accordingly.
// - with short/long distinction, react only after the press is classified.
// - press held at least threshold (200 ms to 65.535 s, default 500 ms) is long.
// - programmable delay between successive commands, zero to 20 s, default zero.
// - mode bit selects one shared object or a separate object per step.
// - in multiple-object mode each slot has its own enable bit.
// - per-slot data type: bit, unsigned byte, percentage or HVAC mode encoding.
// - multiple-object mode with distinction: per-slot long value sent on long press.
// - single-object mode cycles 2, 3 or 4 values, default 3, one shared type.
// - single-object mode with distinction: each value has a long-press alternative.
// - contact debounced with 10 to 150 ms selectable time, default 50 ms.
// - channel function none emits nothing; the input is still debounced and shown on pressed_o.
`timescale 1ns/10ps
`default_nettype none
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYC_PER_MS
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             contact_i,
  input  wire bcs_pkg::bcs_cfg_t cfg_i,
  input  wire logic             cmd_ready_i,
  output logic                  cmd_valid_o,
  output bcs_pkg::bcs_cmd_t     cmd_o,
  output logic                  pressed_o,
  output logic                  busy_o
);
  import bcs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_WAIT_REL,
    ST_SEND,
    ST_DELAY
  } bcs_state_t;

  function automatic logic [7:0] deb_time(input logic [2:0] sel);
    case (sel)
      3'd0:    deb_time = DEB_MS_0;
      3'd1:    deb_time = DEB_MS_1;
      3'd2:    deb_time = DEB_MS_2;
      3'd3:    deb_time = DEB_MS_3;
      3'd4:    deb_time = DEB_MS_4;
      3'd5:    deb_time = DEB_MS_5;
      3'd6:    deb_time = DEB_MS_6;
      default: deb_time = DEB_MS_7;
    endcase
  endfunction

  // formats a raw configured value into the wire encoding of its type
  function automatic logic [7:0] encode(input bcs_type_t t, input logic [7:0] v);
    logic [7:0]  pct;
    logic [15:0] scaled;
    pct    = (v > PCT_FULL) ? PCT_FULL : v;
    scaled = 16'(pct) * 16'(BYTE_FULL) + 16'(PCT_FULL / 8'd2);
    case (t)
      BCS_TYPE_BIT:  encode = {7'd0, v[0]};
      BCS_TYPE_U8:   encode = v;
      BCS_TYPE_PCT:  encode = 8'(scaled / 16'(PCT_FULL));
      BCS_TYPE_HVAC: encode = (v > HVAC_MAX) ? HVAC_MAX : v;
      default:       encode = v;
    endcase
  endfunction

  // next step after last; fresh means nothing emitted yet; bit 2 set when one exists
  function automatic logic [2:0] next_step(input logic [1:0] last, input logic fresh,
                                           input logic single, input logic [2:0] count,
                                           input logic [3:0] en);
    logic [2:0] n;
    logic [1:0] cand;
    logic       found;
    n     = (count < COUNT_MIN) ? COUNT_MIN : ((count > COUNT_MAX) ? COUNT_MAX : count);
    found = 1'b0;
    cand  = 2'd0;
    if (single) begin
      found = 1'b1;
      cand  = (fresh || ({1'b0, last} >= n - 3'd1)) ? 2'd0 : last + 2'd1;
    end else begin
      for (int k = 1; k <= NUM_SLOTS; k++) begin
        logic [1:0] probe;
        probe = fresh ? 2'(k - 1) : last + 2'(k);
        if (!found && en[probe]) begin
          found = 1'b1;
          cand  = probe;
        end
      end
    end
    next_step = {found, cand};
  endfunction

  // input synchroniser, then polarity, then debounce
  logic       sync1_q;
  logic       sync2_q;
  logic       stable_q;
  logic       stable_prev_q;
  logic [7:0] deb_cnt_q;
  logic [7:0] deb_cnt_d;
  logic       stable_d;
  logic       raw_pressed;

  // 1 ms tick from the reference clock
  logic [31:0] pre_q;
  logic        tick;
  logic        pre_restart;

  bcs_state_t  state_q;
  bcs_state_t  state_d;
  logic [15:0] ms_q;
  logic [1:0]  last_q;
  logic        fresh_q;
  bcs_cmd_t    cmd_q;

  assign raw_pressed = cfg_i.contact_nc ? ~sync2_q : sync2_q;
  assign tick        = (pre_q == TICK_CYCLES - 1);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= contact_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_q <= 32'd0;
    end else if (pre_restart || tick) begin
      pre_q <= 32'd0;
    end else begin
      pre_q <= pre_q + 32'd1;
    end
  end

  // level must hold unchanged for the whole debounce time; any bounce restarts it
  always_comb begin
    stable_d  = stable_q;
    deb_cnt_d = deb_cnt_q;
    if (raw_pressed == stable_q) begin
      deb_cnt_d = 8'd0;
    end else if (tick) begin
      if (deb_cnt_q + 8'd1 >= deb_time(cfg_i.debounce_sel)) begin
        stable_d  = raw_pressed;
        deb_cnt_d = 8'd0;
      end else begin
        deb_cnt_d = deb_cnt_q + 8'd1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stable_q      <= 1'b0;
      stable_prev_q <= 1'b0;
      deb_cnt_q     <= 8'd0;
    end else begin
      stable_q      <= stable_d;
      stable_prev_q <= stable_q;
      deb_cnt_q     <= deb_cnt_d;
    end
  end

  wire        press_evt   = stable_q & ~stable_prev_q;
  wire        release_evt = ~stable_q & stable_prev_q;
  wire [15:0] long_lim    = (cfg_i.long_ms < LONG_MIN_MS) ? LONG_MIN_MS : cfg_i.long_ms;
  wire [15:0] delay_lim   = (cfg_i.delay_ms > DELAY_MAX_MS) ? DELAY_MAX_MS : cfg_i.delay_ms;
  wire        long_hit    = tick && (ms_q + 16'd1 >= long_lim);
  wire        delay_done  = (ms_q >= delay_lim);
  wire [2:0]  nxt         = next_step(last_q, fresh_q, cfg_i.single_obj,
                                      cfg_i.value_count, cfg_i.slot_en);
  wire        have_step   = nxt[2];
  wire [1:0]  step        = nxt[1:0];

  // single mode uses one shared type; multi mode takes the slot's own type
  wire bcs_type_t step_type = cfg_i.single_obj ? cfg_i.shared_type
                                               : cfg_i.slot_type[step];

  // the emission decision: classified short or long, or unclassified when distinction is off
  logic emit;
  logic emit_long;

  always_comb begin
    state_d     = state_q;
    emit        = 1'b0;
    emit_long   = 1'b0;
    pre_restart = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (press_evt) begin
          if (cfg_i.long_en) begin
            state_d     = ST_HOLD;
            pre_restart = 1'b1;
          end else begin
            emit = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (release_evt) begin
          emit = 1'b1;
        end else if (long_hit) begin
          emit      = 1'b1;
          emit_long = 1'b1;
        end
      end
      ST_WAIT_REL: begin
        if (!stable_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_SEND: begin
        if (cmd_ready_i) begin
          state_d     = ST_DELAY;
          pre_restart = 1'b1;
        end
      end
      ST_DELAY: begin
        // presses here are dropped so the sequence spacing stays intact
        if (delay_done) begin
          state_d = ST_WAIT_REL;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (emit) begin
      state_d = have_step ? ST_SEND : ST_WAIT_REL;
    end
    if (!cfg_i.enable) begin
      state_d = ST_IDLE;
      emit    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      ms_q    <= 16'd0;
      last_q  <= 2'd0;
      fresh_q <= 1'b1;
      cmd_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        ms_q <= 16'd0;
      end else if (tick && ms_q != 16'hffff) begin
        ms_q <= ms_q + 16'd1;
      end
      if (emit && have_step) begin
        last_q        <= step;
        fresh_q       <= 1'b0;
        cmd_q.slot    <= step;
        cmd_q.dtype   <= step_type;
        cmd_q.is_long <= emit_long;
        cmd_q.data    <= encode(step_type, emit_long ? cfg_i.value_long[step]
                                                     : cfg_i.value_short[step]);
      end
    end
  end

  assign cmd_valid_o = (state_q == ST_SEND);
  assign cmd_o       = cmd_q;
  assign pressed_o   = stable_q;
  assign busy_o      = (state_q == ST_SEND) || (state_q == ST_DELAY);

endmodule
`default_nettype wire

// >>> tb/bcs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module bcs_properties
  import bcs_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire logic              contact_i,
  input wire bcs_pkg::bcs_cfg_t cfg_i,
  input wire logic              cmd_ready_i,
  input wire logic              cmd_valid_o,
  input wire bcs_pkg::bcs_cmd_t cmd_o,
  input wire logic              pressed_o,
  input wire logic              busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_hold;
    cmd_valid_o && !cmd_ready_i && cfg_i.enable |=> cmd_valid_o && $stable(cmd_o);
  endproperty
  a_hold: assert property (p_hold) else $error("command not held");
  property p_busy;
    cmd_valid_o |-> busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("offer while idle");
  property p_none;
    !cfg_i.enable ##1 !cfg_i.enable |-> !cmd_valid_o;
  endproperty
  a_none: assert property (p_none) else $error("offer while off");
  property p_react;
    cfg_i.enable && !cfg_i.long_en && cfg_i.single_obj && !busy_o && $rose(pressed_o)
      |=> cmd_valid_o;
  endproperty
  a_react: assert property (p_react) else $error("press not answered");
  property p_wait;
    cfg_i.long_en && !busy_o && $rose(pressed_o) |=> !cmd_valid_o [*8];
  endproperty
  a_wait: assert property (p_wait) else $error("sent before classified");
  property p_bit;
    cmd_valid_o && cmd_o.dtype == BCS_TYPE_BIT |-> cmd_o.data[7:1] == 7'h00;
  endproperty
  a_bit: assert property (p_bit) else $error("bit value too wide");
  property p_slot;
    cmd_valid_o && !cfg_i.single_obj |-> cfg_i.slot_en[cmd_o.slot];
  endproperty
  a_slot: assert property (p_slot) else $error("disabled slot sent");
  property p_count;
    cmd_valid_o && cfg_i.single_obj |-> {1'b0, cmd_o.slot} < cfg_i.value_count;
  endproperty
  a_count: assert property (p_count) else $error("step beyond count");
  c_long: cover property (cmd_valid_o && cmd_ready_i && cmd_o.is_long);
  c_last: cover property (cmd_valid_o && cfg_i.single_obj && cmd_o.slot == 2'h3);
  c_delay: cover property ($fell(busy_o));
endmodule
bind bcs_sequencer bcs_properties bcs_properties_inst (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .contact_i(contact_i), .cfg_i(cfg_i),
  .cmd_ready_i(cmd_ready_i), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
  .pressed_o(pressed_o), .busy_o(busy_o));
`default_nettype wire

// >>> tb/bcs_contact_model.sv
`timescale 1ns/10ps
`default_nettype none
module bcs_contact_model (
  input  wire logic ref_clk_i,
  input  wire logic nc_i,
  output logic      contact_o
);
  logic act = 1'b0;
  // a closed-at-rest contact opens the pin when pressed
  assign contact_o = act ^ nc_i;
  // bursts of 3-cycle bounces on both edges, far below any debounce time
  task automatic press(input int hold);
    for (int i = 0; i < 10; i++) begin
      act = ~i[0];
      repeat ((i == 4) ? hold : 3) @(negedge ref_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/test_bcs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_bcs_sequencer;
  import bcs_pkg::*;
  localparam int TK = 10;
  logic     ref_clk_i = 1'b0;
  logic     reset_i   = 1'b1;
  logic     rdy       = 1'b0;
  logic     contact, vld, prs, bsy, lg, seen;
  bcs_cfg_t cfg = '0;
  bcs_cmd_t cmd;
  logic [1:0] last;
  int       bad_count = 0;
  int       compares  = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  bcs_sequencer #(.TICK_CYCLES(TK)) bcs_sequencer_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .contact_i(contact), .cfg_i(cfg),
    .cmd_ready_i(rdy), .cmd_valid_o(vld), .cmd_o(cmd), .pressed_o(prs), .busy_o(bsy));
  bcs_contact_model bcs_contact_model_inst (
    .ref_clk_i(ref_clk_i), .nc_i(cfg.contact_nc), .contact_o(contact));
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_cmd(input bcs_cmd_t got, input bcs_cmd_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] enc(input bcs_type_t t, input logic [7:0] v);
    logic [15:0] m;
    m = (v > PCT_FULL) ? 16'h0064 : {8'h00, v};
    case (t)
      BCS_TYPE_BIT: return {7'h00, v[0]};
      BCS_TYPE_U8: return v;
      BCS_TYPE_PCT: return 8'((m * 16'h00ff + 16'h0032) / 16'h0064);
      default: return (v > HVAC_MAX) ? HVAC_MAX : v;
    endcase
  endfunction
  function automatic logic [1:0] nxt(input logic [1:0] l);
    if (cfg.single_obj) return ({1'b0, l} + 3'h1 >= cfg.value_count) ? 2'h0 : l + 2'h1;
    for (int i = 1; i < 5; i++) if (cfg.slot_en[2'(l + i)]) return 2'(l + i);
    return l;
  endfunction
  task automatic do_press(input int hold);
    bcs_cmd_t e;
    int n;
    int d;
    last = nxt(last);
    e.slot = last;
    e.dtype = cfg.single_obj ? cfg.shared_type : cfg.slot_type[last];
    e.is_long = lg;
    e.data = enc(e.dtype, lg ? cfg.value_long[last] : cfg.value_short[last]);
    fork
      bcs_contact_model_inst.press(hold);
      begin
        n = 0;
        while (vld !== 1'b1 && n < 9000) begin
          @(negedge ref_clk_i);
          n++;
        end
        repeat ($urandom_range(3)) @(negedge ref_clk_i);
        check_flag(vld, 1'b1);
        check_cmd(cmd, e);
        // a short press is only classified at release, so the level is already low by then
        check_flag(prs, !cfg.long_en || lg);
        rdy = 1'b1;
        @(negedge ref_clk_i);
        rdy = 1'b0;
        n = 0;
        while (bsy === 1'b1 && n < 9000) begin
          @(negedge ref_clk_i);
          n++;
        end
        d = int'(cfg.delay_ms) * TK;
        check_flag(n inside {[d : d + 2]}, 1'b1);
      end
    join
    repeat (250) @(negedge ref_clk_i);
  endtask
  initial begin
    // about twice the longest expected run of all configurations
    #400000;
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h6ae19d5a));
    for (int k = 0; k < 6; k++) begin
      @(negedge ref_clk_i);
      reset_i = 1'b1;
      cfg = bcs_cfg_t'(120'({$urandom(), $urandom(), $urandom(), $urandom()}));
      cfg.enable = 1'b1;
      cfg.long_en = k[0];
      cfg.single_obj = k > 2;
      cfg.value_count = 3'(k % 3 + 2);
      // short debounce codes only, so the 300-cycle press still outlasts the debounce time
      cfg.debounce_sel = 3'(k % 2);
      cfg.contact_nc = k[1];
      cfg.long_ms = LONG_MIN_MS;
      cfg.delay_ms = {14'h0000, cfg.delay_ms[1:0]};
      if (k == 0) begin
        cfg.slot_en = 4'hf;
        cfg.slot_type[0] = BCS_TYPE_BIT;
        cfg.slot_type[1] = BCS_TYPE_U8;
        cfg.slot_type[2] = BCS_TYPE_PCT;
        cfg.slot_type[3] = BCS_TYPE_HVAC;
        cfg.value_short[2] = PCT_FULL;
      end
      if (cfg.slot_en == 4'h0) cfg.slot_en = 4'h9;
      last = 2'h3;
      repeat (12) @(negedge ref_clk_i);
      reset_i = 1'b0;
      for (int j = 0; j < 5; j++) begin
        lg = cfg.long_en && (j == 1 || (j > 1 && $urandom_range(1) == 1));
        do_press(lg ? 2200 : 300);
      end
    end
    cfg.enable = 1'b0;
    seen = 1'b0;
    fork
      bcs_contact_model_inst.press(300);
      repeat (500) begin
        @(negedge ref_clk_i);
        seen |= vld;
      end
    join
    check_flag(seen, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
